// [inc/tgd_map.svh]
// Register offsets, field positions, reset values and divider taps
`ifndef TGD_MAP_SVH
`define TGD_MAP_SVH

`define TGD_ADDR_SC1 8'h00
`define TGD_ADDR_SC2 8'h04
`define TGD_ADDR_TBC 8'h08
`define TGD_ADDR_STAT 8'h0c

`define TGD_SC1_STOP 0
`define TGD_SC2_SYSTEM_CLOCK_SELECT 0
`define TGD_SC2_XEN 1
`define TGD_SC2_XTEN 2
`define TGD_SC2_SLEEP 3
`define TGD_TBC_DV7 0

`define TGD_STAT_MODE_LSB 0
`define TGD_STAT_MC_LSB 3
`define TGD_STAT_WARM 5

`define TGD_SYSTEM_CLOCK_SELECT_RST 1'b0
`define TGD_XEN_RST 1'b1
`define TGD_XTEN_RST 1'b0
`define TGD_DV7_RST 1'b0
`define TGD_MC_RST 2'h0

`define TGD_DVO_STAGE 13
`define TGD_TBT_STAGE 15
`define TGD_WDT_STAGE 17
`define TGD_TMR_STAGE 9
`define TGD_LCD_STAGE 11

`endif

// [inc/tgd_pkg.sv]
// Types shared by the timing generator and its divider chain
package tgd_pkg;

    typedef enum logic [2:0] {
        single_clock_run,
        dual_clock_fast_run,
        slow_both_osc_run,
        slow_only_run,
        sleep_one,
        sleep_two,
        stop_hold,
        warm_up
    } tgd_mode_t;

    typedef enum logic {
        src7_stage6,
        src7_lowfreq
    } tgd_src7_t;

endpackage : tgd_pkg

// [inc/tgd_div_if.sv]
// Control and tap signals between the mode logic and the divider chain
`timescale 1ns/1ps
interface tgd_div_if
    import tgd_pkg::*;
#(
    parameter int STG_W = 23
);
    logic clear;
    logic low_run;
    logic fs_tick;
    tgd_src7_t src7;
    logic [STG_W-1:0] stages;

    modport ctl (
        output clear,
        output low_run,
        output fs_tick,
        output src7,
        input stages
    );

    modport div (
        input clear,
        input low_run,
        input fs_tick,
        input src7,
        output stages
    );
endinterface : tgd_div_if

// [verilog/tgd_divider.sv]
// Prescaler plus binary divider chain with selectable 7th-stage input
`timescale 1ns/1ps
module tgd_divider
    import tgd_pkg::*;
#(
    parameter int PRE_W = 2,
    parameter int DIV_W = 21,
    parameter int LOW_STAGES = 6
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    tgd_div_if.div dif
);
    localparam int LO_W = PRE_W + LOW_STAGES;
    localparam int HI_W = DIV_W - LOW_STAGES;

    logic [LO_W-1:0] lo;
    logic [LO_W-1:0] next_lo;
    logic [HI_W-1:0] hi;
    logic [HI_W-1:0] next_hi;
    logic hi_tick;

    // Binary counting: stage n toggles at its input over 2**n
    always_comb begin
        if (dif.src7 == src7_lowfreq) begin
            hi_tick = dif.fs_tick;
        end else begin
            hi_tick = dif.low_run && (&lo);
        end
        next_lo = lo;
        next_hi = hi;
        if (dif.clear) begin
            next_lo = '0;
            next_hi = '0;
        end else begin
            if (dif.low_run) begin
                next_lo = lo + 1'b1;
            end
            if (hi_tick) begin
                next_hi = hi + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lo <= '0;
            hi <= '0;
        end else begin
            lo <= next_lo;
            hi <= next_hi;
        end
    end

    assign dif.stages = {hi, lo};
endmodule : tgd_divider

// [verilog/tgd_timing_gen.sv]
// Timing generator: mode control, divider taps and machine cycle states
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "tgd_map.svh"
module tgd_timing_gen
    import tgd_pkg::*;
#(
    parameter int PRE_W = 2,
    parameter int DIV_W = 21,
    parameter int LOW_STAGES = 6,
    parameter int WARM_STAGE = 14
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic low_osc_in_pin_i,
    input wire logic stop_release_i,
    input wire logic wake_i,
    output logic sys_tick_o,
    output logic [1:0] mcyc_state_o,
    output logic core_lowfreq_o,
    output logic hf_osc_en_o,
    output logic lf_osc_en_o,
    output logic lf_pins_port_o,
    output logic divider_pulse_out_o,
    output logic tbt_src_o,
    output logic wdt_src_o,
    output logic timer_src_o,
    output logic lcd_src_o,
    output logic warmup_o,
    output tgd_mode_t mode_o
);
    localparam int STG_W = PRE_W + DIV_W;
    localparam int OFS = PRE_W - 1;

    tgd_mode_t mode;
    tgd_mode_t next_mode;
    tgd_mode_t ret_mode;
    tgd_mode_t next_ret_mode;
    logic from_fast;
    logic next_from_fast;

    logic stop_req;
    logic next_stop_req;
    logic sleep_req;
    logic next_sleep_req;
    logic system_clock_select;
    logic next_system_clock_select;
    logic hf_enable;
    logic next_hf_enable;
    logic lf_enable;
    logic next_lf_enable;
    logic div7_lowfreq_select;
    logic next_div7_lowfreq_select;

    logic lf_pin_q;
    logic next_lf_pin_q;
    logic next_sys_tick;
    logic [1:0] next_mcyc_state;
    logic next_core_lowfreq;
    logic next_hf_osc_en;
    logic next_lf_osc_en;
    logic [7:0] next_rdata;
    logic warm_done;
    logic main_tick;

    tgd_div_if #(.STG_W(STG_W)) dif ();

    tgd_divider #(
        .PRE_W(PRE_W),
        .DIV_W(DIV_W),
        .LOW_STAGES(LOW_STAGES)
    ) u_div (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .dif(dif.div)
    );

    // Warm-up ends when the chosen divider tap first rises
    assign warm_done = dif.stages[WARM_STAGE + OFS];

    // Operating mode sequencing
    always_comb begin
        next_mode = mode;
        next_ret_mode = ret_mode;
        next_from_fast = from_fast;
        case (mode)
            single_clock_run: begin
                if (stop_req) begin
                    next_mode = stop_hold;
                    next_ret_mode = mode;
                    next_from_fast = 1'b1;
                end else if (lf_enable) begin
                    next_mode = dual_clock_fast_run;
                end
            end
            dual_clock_fast_run: begin
                if (stop_req) begin
                    next_mode = stop_hold;
                    next_ret_mode = mode;
                    next_from_fast = 1'b1;
                end else if (!lf_enable) begin
                    next_mode = single_clock_run;
                end else if (system_clock_select) begin
                    next_mode = slow_both_osc_run;
                end
            end
            slow_both_osc_run: begin
                if (stop_req) begin
                    next_mode = stop_hold;
                    next_ret_mode = mode;
                    next_from_fast = 1'b0;
                end else if (sleep_req) begin
                    next_mode = sleep_two;
                end else if (!system_clock_select) begin
                    next_mode = dual_clock_fast_run;
                end else if (!hf_enable) begin
                    next_mode = slow_only_run;
                end
            end
            slow_only_run: begin
                if (stop_req) begin
                    next_mode = stop_hold;
                    next_ret_mode = mode;
                    next_from_fast = 1'b0;
                end else if (sleep_req) begin
                    next_mode = sleep_one;
                end else if (hf_enable) begin
                    next_mode = slow_both_osc_run;
                end
            end
            sleep_one: begin
                if (wake_i) begin
                    next_mode = slow_only_run;
                end
            end
            sleep_two: begin
                if (wake_i) begin
                    next_mode = slow_both_osc_run;
                end
            end
            stop_hold: begin
                if (stop_release_i) begin
                    next_mode = warm_up;
                end
            end
            warm_up: begin
                if (warm_done) begin
                    next_mode = ret_mode;
                end
            end
            default: begin
                next_mode = single_clock_run;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode <= single_clock_run;
            ret_mode <= single_clock_run;
            from_fast <= 1'b1;
        end else begin
            mode <= next_mode;
            ret_mode <= next_ret_mode;
            from_fast <= next_from_fast;
        end
    end

    // Divider control: clear on STOP entry and on release
    always_comb begin
        dif.clear = (next_mode == stop_hold) != (mode == stop_hold);
        dif.fs_tick = lf_osc_en_o && low_osc_in_pin_i && !lf_pin_q;
        case (mode)
            slow_only_run, sleep_one, sleep_two, stop_hold: begin
                dif.low_run = 1'b0;
            end
            warm_up: begin
                dif.low_run = from_fast;
            end
            default: begin
                dif.low_run = 1'b1;
            end
        endcase
        case (mode)
            slow_both_osc_run, slow_only_run, sleep_one, sleep_two: begin
                dif.src7 = src7_lowfreq;
            end
            warm_up: begin
                dif.src7 = from_fast ? src7_stage6 : src7_lowfreq;
            end
            default: begin
                // Relies on software keeping the bit clear until fs is stable
                if (div7_lowfreq_select && lf_enable) begin
                    dif.src7 = src7_lowfreq;
                end else begin
                    dif.src7 = src7_stage6;
                end
            end
        endcase
    end

    // Main system clock tick: fc in fast modes, fs in slow modes
    always_comb begin
        case (mode)
            single_clock_run, dual_clock_fast_run: begin
                main_tick = 1'b1;
            end
            slow_both_osc_run, slow_only_run: begin
                main_tick = dif.fs_tick;
            end
            default: begin
                main_tick = 1'b0;
            end
        endcase
    end

    // Software registers; a write beats the hardware clear of a command
    always_comb begin
        next_stop_req = stop_req;
        next_sleep_req = sleep_req;
        next_system_clock_select = system_clock_select;
        next_hf_enable = hf_enable;
        next_lf_enable = lf_enable;
        next_div7_lowfreq_select = div7_lowfreq_select;
        if (next_mode == stop_hold) begin
            next_stop_req = 1'b0;
        end
        if (next_mode == sleep_one || next_mode == sleep_two) begin
            next_sleep_req = 1'b0;
        end
        if (wr_i) begin
            if (addr_i == `TGD_ADDR_SC1) begin
                next_stop_req = wdata_i[`TGD_SC1_STOP];
            end else if (addr_i == `TGD_ADDR_SC2) begin
                next_system_clock_select = wdata_i[`TGD_SC2_SYSTEM_CLOCK_SELECT];
                next_hf_enable = wdata_i[`TGD_SC2_XEN];
                next_lf_enable = wdata_i[`TGD_SC2_XTEN];
                next_sleep_req = wdata_i[`TGD_SC2_SLEEP];
            end else if (addr_i == `TGD_ADDR_TBC) begin
                next_div7_lowfreq_select = wdata_i[`TGD_TBC_DV7];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stop_req <= 1'b0;
            sleep_req <= 1'b0;
            system_clock_select <= `TGD_SYSTEM_CLOCK_SELECT_RST;
            hf_enable <= `TGD_XEN_RST;
            lf_enable <= `TGD_XTEN_RST;
            div7_lowfreq_select <= `TGD_DV7_RST;
        end else begin
            stop_req <= next_stop_req;
            sleep_req <= next_sleep_req;
            system_clock_select <= next_system_clock_select;
            hf_enable <= next_hf_enable;
            lf_enable <= next_lf_enable;
            div7_lowfreq_select <= next_div7_lowfreq_select;
        end
    end

    // Registered outputs and read data
    always_comb begin
        next_lf_pin_q = low_osc_in_pin_i;
        next_sys_tick = main_tick;
        next_mcyc_state = mcyc_state_o;
        if (main_tick) begin
            next_mcyc_state = mcyc_state_o + 2'h1;
        end
        next_core_lowfreq = (next_mode == slow_both_osc_run) ||
            (next_mode == slow_only_run) || (next_mode == sleep_one) ||
            (next_mode == sleep_two);
        case (next_mode)
            stop_hold: begin
                next_hf_osc_en = 1'b0;
            end
            single_clock_run, dual_clock_fast_run: begin
                next_hf_osc_en = 1'b1;
            end
            default: begin
                next_hf_osc_en = next_hf_enable;
            end
        endcase
        // Low oscillator stays off in single clock, its pins are ports
        next_lf_osc_en = next_lf_enable && (next_mode != stop_hold) &&
            (next_mode != single_clock_run);
        next_rdata = 8'h00;
        if (rd_i) begin
            if (addr_i == `TGD_ADDR_SC1) begin
                next_rdata[`TGD_SC1_STOP] = stop_req;
            end else if (addr_i == `TGD_ADDR_SC2) begin
                next_rdata[`TGD_SC2_SYSTEM_CLOCK_SELECT] = system_clock_select;
                next_rdata[`TGD_SC2_XEN] = hf_enable;
                next_rdata[`TGD_SC2_XTEN] = lf_enable;
                next_rdata[`TGD_SC2_SLEEP] = sleep_req;
            end else if (addr_i == `TGD_ADDR_TBC) begin
                next_rdata[`TGD_TBC_DV7] = div7_lowfreq_select;
            end else if (addr_i == `TGD_ADDR_STAT) begin
                next_rdata[`TGD_STAT_MODE_LSB +: 3] = mode;
                next_rdata[`TGD_STAT_MC_LSB +: 2] = mcyc_state_o;
                next_rdata[`TGD_STAT_WARM] = (mode == warm_up);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lf_pin_q <= 1'b0;
            sys_tick_o <= 1'b0;
            mcyc_state_o <= `TGD_MC_RST;
            core_lowfreq_o <= 1'b0;
            hf_osc_en_o <= 1'b1;
            lf_osc_en_o <= 1'b0;
            lf_pins_port_o <= 1'b1;
            divider_pulse_out_o <= 1'b0;
            tbt_src_o <= 1'b0;
            wdt_src_o <= 1'b0;
            timer_src_o <= 1'b0;
            lcd_src_o <= 1'b0;
            warmup_o <= 1'b0;
            mode_o <= single_clock_run;
            rdata_o <= 8'h00;
        end else begin
            lf_pin_q <= next_lf_pin_q;
            sys_tick_o <= next_sys_tick;
            mcyc_state_o <= next_mcyc_state;
            core_lowfreq_o <= next_core_lowfreq;
            hf_osc_en_o <= next_hf_osc_en;
            lf_osc_en_o <= next_lf_osc_en;
            lf_pins_port_o <= (next_mode == single_clock_run);
            divider_pulse_out_o <= dif.stages[`TGD_DVO_STAGE + OFS];
            tbt_src_o <= dif.stages[`TGD_TBT_STAGE + OFS];
            wdt_src_o <= dif.stages[`TGD_WDT_STAGE + OFS];
            timer_src_o <= dif.stages[`TGD_TMR_STAGE + OFS];
            lcd_src_o <= dif.stages[`TGD_LCD_STAGE + OFS];
            warmup_o <= (next_mode == warm_up);
            mode_o <= next_mode;
            rdata_o <= next_rdata;
        end
    end
endmodule : tgd_timing_gen

// [bench/tgd_timing_gen_monitor.sv]
// Port checker for the timing generator, bound to its top module
`timescale 1ns/1ps
module tgd_timing_gen_monitor
    import tgd_pkg::*;
#(
    parameter int WARM_STAGE = 14
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic sys_tick_o,
    input wire logic [1:0] mcyc_state_o,
    input wire logic core_lowfreq_o,
    input wire logic hf_osc_en_o,
    input wire logic lf_pins_port_o,
    input wire logic divider_pulse_out_o,
    input wire logic timer_src_o,
    input wire logic lcd_src_o,
    input wire logic warmup_o,
    input wire tgd_mode_t mode_o
);
    // Slack covers the registered exit from warm-up
    localparam int WARM_MAX = 2 ** (WARM_STAGE + 1) + 8;
    int warm_cnt;
    int next_warm_cnt;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    always_comb begin
        next_warm_cnt = warmup_o ? warm_cnt + 1 : 0;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warm_cnt <= 0;
        end else begin
            warm_cnt <= next_warm_cnt;
        end
    end

    AST_MCYC_STEP: assert property (
        sys_tick_o |-> mcyc_state_o == $past(mcyc_state_o) + 2'h1)
        else $error("machine state did not step on tick");
    AST_MCYC_HOLD: assert property (
        !sys_tick_o |-> $stable(mcyc_state_o))
        else $error("machine state moved without tick");
    // Tick is launched from the mode of the previous cycle
    AST_FAST_TICK: assert property (
        $past(rstn_i) && $past(mode_o) inside {single_clock_run,
        dual_clock_fast_run} |-> sys_tick_o)
        else $error("fast mode missed a main clock tick");
    AST_SINGLE_CLK: assert property (
        mode_o == single_clock_run
        |-> hf_osc_en_o && lf_pins_port_o && !core_lowfreq_o)
        else $error("single mode clock or pin state wrong");
    AST_SLOW_CORE: assert property (
        mode_o inside {slow_both_osc_run, slow_only_run, sleep_one, sleep_two}
        |-> core_lowfreq_o && !lf_pins_port_o)
        else $error("slow mode core not on low clock");
    AST_STOP_CLEAR: assert property (
        // Taps still show pre-clear stages on the entry cycle
        mode_o == stop_hold && $past(mode_o) == stop_hold
        |-> !sys_tick_o && !timer_src_o && !lcd_src_o && !divider_pulse_out_o)
        else $error("divider not cleared in stop");
    AST_WARM_FLAG: assert property (
        warmup_o == (mode_o == warm_up))
        else $error("warm-up flag disagrees with mode");
    AST_WARM_ENTRY: assert property (
        mode_o == warm_up |-> $past(mode_o) inside {stop_hold, warm_up})
        else $error("warm-up entered without stop");
    AST_WARM_LEN: assert property (
        warm_cnt <= WARM_MAX)
        else $error("warm-up lasted too long");
    AST_TAP_ORDER: assert property (
        $rose(lcd_src_o) |-> !timer_src_o)
        else $error("lower tap high when higher tap rose");
    AST_RD_IDLE: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    AST_RD_STATUS: assert property (
        $past(rd_i) && $past(addr_i) == 8'h0c
        |-> rdata_o[2:0] == $past(mode_o))
        else $error("status read shows wrong mode");
endmodule : tgd_timing_gen_monitor

bind tgd_timing_gen tgd_timing_gen_monitor #(
    .WARM_STAGE(WARM_STAGE)
) mon_u (
    .mclk_i, .rstn_i, .addr_i, .rd_i, .rdata_o, .sys_tick_o, .mcyc_state_o,
    .core_lowfreq_o, .hf_osc_en_o, .lf_pins_port_o, .divider_pulse_out_o,
    .timer_src_o, .lcd_src_o, .warmup_o, .mode_o
);

// [bench/tgd_timing_gen_bench.sv]
// Directed bench: register calls, mode walk and divider tap timing
`timescale 1ns/1ps
module tgd_timing_gen_bench;
    import tgd_pkg::*;
    logic mclk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, wake_i = 0;
    logic low_osc_in_pin_i = 0, stop_release_i = 0, lf_run = 0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
    logic sys_tick_o, core_lowfreq_o, hf_osc_en_o, lf_osc_en_o;
    logic lf_pins_port_o, divider_pulse_out_o, tbt_src_o, wdt_src_o;
    logic timer_src_o, lcd_src_o, warmup_o;
    logic [1:0] mcyc_state_o;
    tgd_mode_t mode_o;
    int errors = 0, tests_run = 0, lf_cnt = 0, n;

    initial forever #2 mclk_i = ~mclk_i;

    // Slow pin: rising edge every 16 main clocks
    always @(posedge mclk_i) begin
        if (lf_run) begin
            lf_cnt <= lf_cnt + 1;
            if (lf_cnt % 8 == 7) low_osc_in_pin_i <= ~low_osc_in_pin_i;
        end
    end

    tgd_timing_gen #(.WARM_STAGE(8)) dut_u (
        .mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .low_osc_in_pin_i, .stop_release_i, .wake_i, .sys_tick_o,
        .mcyc_state_o, .core_lowfreq_o, .hf_osc_en_o, .lf_osc_en_o,
        .lf_pins_port_o, .divider_pulse_out_o, .tbt_src_o, .wdt_src_o,
        .timer_src_o, .lcd_src_o, .warmup_o, .mode_o
    );

    task summarize;
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
            input string nm);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, e, rdata_o & m);
    endtask : rd

    task wait_mode(input tgd_mode_t m, input string nm);
        int i;
        i = 0;
        while (mode_o !== m && i < 2000) begin
            @(posedge mclk_i);
            #1;
            i++;
        end
        chk(nm, {5'h0, m}, {5'h0, mode_o});
        if (i >= 2000) summarize();
    endtask : wait_mode

    // Cycles between two toggles of the stage-9 tap
    task half(input int e, input string nm);
        int i;
        logic v;
        for (i = 0; i < 2; i++) begin
            v = timer_src_o;
            n = 0;
            while (timer_src_o === v && n < 5000) begin
                @(posedge mclk_i);
                #1;
                n++;
            end
        end
        tests_run++;
        if (n != e) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", nm, e, n);
        end
        if (n >= 5000 || n != e) summarize();
    endtask : half

    initial begin
        repeat (20) @(posedge mclk_i);
        chk("mode_rst", 8'h00, {5'h0, mode_o});
        chk("osc_rst", 8'h05, {5'h0, hf_osc_en_o, lf_osc_en_o,
            lf_pins_port_o});
        chk("taps_rst", 8'h00, {3'h0, divider_pulse_out_o, tbt_src_o,
            wdt_src_o, timer_src_o, lcd_src_o});
        rstn_i <= 1'b1;
        rd(8'h0c, 8'h07, 8'h00, "status_mode");
        rd(8'h08, 8'hff, 8'h00, "tbc_rst");
        rd(8'h04, 8'h0f, 8'h02, "sc2_rst");
        wr(8'h20, 8'hff);
        rd(8'h20, 8'hff, 8'h00, "unmapped");
        half(1024, "stage9_fast");
        wr(8'h04, 8'h06);
        wait_mode(dual_clock_fast_run, "to_dual");
        chk("dual_osc", 8'h06, {5'h0, hf_osc_en_o, lf_osc_en_o,
            lf_pins_port_o});
        lf_run <= 1'b1;
        // Let the slow clock settle before selecting it
        repeat (64) @(posedge mclk_i);
        wr(8'h08, 8'h01);
        half(64, "stage9_fs");
        wr(8'h04, 8'h07);
        wait_mode(slow_both_osc_run, "to_slow_both");
        n = 0;
        repeat (160) begin
            @(posedge mclk_i);
            #1;
            n += (sys_tick_o === 1'b1);
        end
        chk("fs_ticks", 8'h01, {7'h0, n >= 9 && n <= 11});
        wr(8'h04, 8'h05);
        wait_mode(slow_only_run, "to_slow_only");
        chk("hf_off", 8'h00, {7'h0, hf_osc_en_o});
        wr(8'h04, 8'h0d);
        wait_mode(sleep_one, "to_sleep");
        @(posedge mclk_i);
        wake_i <= 1'b1;
        @(posedge mclk_i);
        wake_i <= 1'b0;
        wait_mode(slow_only_run, "wake");
        wr(8'h04, 8'h07);
        wait_mode(slow_both_osc_run, "hf_back");
        wr(8'h04, 8'h0f);
        wait_mode(sleep_two, "to_sleep_two");
        @(posedge mclk_i);
        wake_i <= 1'b1;
        @(posedge mclk_i);
        wake_i <= 1'b0;
        wait_mode(slow_both_osc_run, "wake_two");
        wr(8'h04, 8'h06);
        wait_mode(dual_clock_fast_run, "back_dual");
        wr(8'h00, 8'h01);
        wait_mode(stop_hold, "to_stop");
        // Taps show the pre-clear stages for one cycle
        @(posedge mclk_i);
        #1;
        chk("stop_taps", 8'h00, {4'h0, divider_pulse_out_o, tbt_src_o,
            timer_src_o, lcd_src_o});
        @(posedge mclk_i);
        stop_release_i <= 1'b1;
        @(posedge mclk_i);
        stop_release_i <= 1'b0;
        wait_mode(warm_up, "to_warm");
        rd(8'h0c, 8'h27, 8'h27, "status_warm");
        // Stage six feeds stage seven here, so warm-up is not fs paced
        n = 0;
        while (warmup_o === 1'b1 && n < 2000) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk("warm_len", 8'h01, {7'h0, n >= 508 && n <= 516});
        wait_mode(dual_clock_fast_run, "warm_done");
        wr(8'h08, 8'h00);
        wr(8'h04, 8'h02);
        wait_mode(single_clock_run, "to_single");
        chk("single_pins", 8'h01, {7'h0, lf_pins_port_o});
        summarize();
    end
endmodule : tgd_timing_gen_bench
